// [logic/dfs_defines.svh]
// Constants for the drive and imaging fault supervisor: register offsets,
// fault bit positions, reset values and timing figures.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef DFS_DEFINES_SVH
`define DFS_DEFINES_SVH

`define DFS_CLK_HZ          10000000
`define DFS_CYC_PER_MS      (`DFS_CLK_HZ / 1000)

// Times in their own units
`define DFS_RUNUP_MS        1000
`define DFS_STOP_MS         4000
`define DFS_SPINUP_MS       60000
`define DFS_TONER_MIN       20
`define DFS_SEQ_BEAT_MS     100
`define DFS_PROC_BEAT_MS    1000
`define DFS_LINE_WINDOW_MS  1000
`define DFS_CTR_GRACE_MS    50

// Levels
`define DFS_LINE_MIN_PPS    600
`define DFS_DENS_MIN_V      350
`define DFS_DENS_MAX_V      450
`define DFS_PAT_MARGIN_MV   1000
`define DFS_PAT_STREAK      15
`define DFS_FUSE_MIN        8'h50
`define DFS_FUSE_MAX        8'hD0

// Register byte offsets
`define DFS_REG_FAULT_LO    12'h000
`define DFS_REG_FAULT_HI    12'h004
`define DFS_REG_CODE        12'h008
`define DFS_REG_SYNC_LIMIT  12'h00C
`define DFS_SYNC_LIMIT_RST  16'h0800

// Fault bit positions
`define DFS_F_MAIN_SPEED    0
`define DFS_F_MAIN_STOP     1
`define DFS_F_DRUM_SPEED    2
`define DFS_F_DRUM_STOP     3
`define DFS_F_BELT_SPEED    4
`define DFS_F_BELT_STOP     5
`define DFS_F_MIRROR        6
`define DFS_F_TONER         7
`define DFS_F_SCAN_SYNC     11
`define DFS_F_LASER         15
`define DFS_F_LINE_SYNC     19
`define DFS_F_BIAS          20
`define DFS_F_CHARGE        32
`define DFS_F_LEAK          36
`define DFS_F_DENSITY       40
`define DFS_F_PATTERN       44
`define DFS_F_COUNTER       48
`define DFS_F_LINK          50
`define DFS_F_SEQ_BEAT      55
`define DFS_F_PROC_BEAT     56
`define DFS_F_SETTING       57
`define DFS_NUM_FAULTS      58

`endif

// [logic/dfs_pkg.sv]
// Types for the drive and imaging fault supervisor.
// Assumes dfs_defines.svh is compiled alongside.
package dfs_pkg;

  typedef enum logic [3:0] {
    DFS_M_IDLE  = 4'b0001,
    DFS_M_RUNUP = 4'b0010,
    DFS_M_RUN   = 4'b0100,
    DFS_M_STOP  = 4'b1000
  } dfs_motor_e;

  // Motor index: 0 main, 1 drum, 2 transfer belt
  typedef struct packed {
    logic        main_on_cmd;
    logic [2:0]  at_speed;
    logic        main_turning;
    logic        belt_turning;
    logic        mirror_at_speed;
    logic [3:0]  toner_motor_on;
    logic [3:0]  toner_low;
    logic [3:0]  scan_sync;
    logic [3:0]  laser_on;
    logic [3:0]  laser_over;
    logic        line_beam;
    logic [11:0] bias_on;
    logic [11:0] bias_ok;
    logic        bias_check;
    logic        charge_check;
    logic [3:0]  charge_ok;
    logic [3:0]  leak;
    logic        density_done;
    logic [1:0]  density_colour;
    logic [8:0]  density_volts;
    logic        pattern_done;
    logic [1:0]  pattern_colour;
    logic [12:0] vsp_mv;
    logic [12:0] vtc_mv;
    logic [1:0]  counter_want;
    logic [1:0]  counter_line;
    logic [4:0]  link_lost;
    logic        seq_beat;
    logic        proc_beat;
    logic [7:0]  fuse_setting;
  } dfs_pins_s;

  typedef struct packed {
    logic       valid;
    logic [5:0] index;
  } dfs_code_s;

endpackage : dfs_pkg

// [logic/dfs_supervisor.sv]
// Drive and imaging fault supervisor with an AHB-Lite register slave.
// Assumes all pins come from other boards and are synchronised here;
// multi-bit samples stand stable at least three cycles around their strobe.
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "dfs_defines.svh"

module dfs_supervisor
  import dfs_pkg::*;
#(
  parameter longint unsigned RUNUP_CYC  = 64'(`DFS_RUNUP_MS) * `DFS_CYC_PER_MS,
  parameter longint unsigned STOP_CYC   = 64'(`DFS_STOP_MS) * `DFS_CYC_PER_MS,
  parameter longint unsigned SPINUP_CYC = 64'(`DFS_SPINUP_MS) * `DFS_CYC_PER_MS,
  parameter longint unsigned TONER_CYC  = 64'(`DFS_TONER_MIN) * 60000 * `DFS_CYC_PER_MS,
  parameter longint unsigned SEQ_CYC    = 64'(`DFS_SEQ_BEAT_MS) * `DFS_CYC_PER_MS,
  parameter longint unsigned PROC_CYC   = 64'(`DFS_PROC_BEAT_MS) * `DFS_CYC_PER_MS,
  parameter longint unsigned WINDOW_CYC = 64'(`DFS_LINE_WINDOW_MS) * `DFS_CYC_PER_MS,
  parameter longint unsigned GRACE_CYC  = 64'(`DFS_CTR_GRACE_MS) * `DFS_CYC_PER_MS,
  parameter int unsigned     LINE_MIN   = `DFS_LINE_MIN_PPS,
  parameter logic [7:0]      FUSE_MIN   = `DFS_FUSE_MIN,
  parameter logic [7:0]      FUSE_MAX   = `DFS_FUSE_MAX
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire dfs_pins_s   pins,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             fault_active,
  output logic      [5:0]  fault_code
);

  localparam int TW = 36;
  localparam logic [TW-1:0] RUNUP_L  = TW'(RUNUP_CYC);
  localparam logic [TW-1:0] STOP_L   = TW'(STOP_CYC);
  localparam logic [TW-1:0] SPINUP_L = TW'(SPINUP_CYC);
  localparam logic [TW-1:0] TONER_L  = TW'(TONER_CYC);
  localparam logic [TW-1:0] SEQ_L    = TW'(SEQ_CYC);
  localparam logic [TW-1:0] PROC_L   = TW'(PROC_CYC);
  localparam logic [TW-1:0] WINDOW_L = TW'(WINDOW_CYC);
  localparam logic [TW-1:0] GRACE_L  = TW'(GRACE_CYC);
  localparam logic [15:0]   LINE_L   = 16'(LINE_MIN);

  dfs_pins_s   meta;
  dfs_pins_s   s;
  dfs_pins_s   prev;
  logic [63:0] faults;
  logic [63:0] raise;
  logic [15:0] sync_limit;
  dfs_motor_e  mstate;
  logic [TW-1:0] mtimer;
  logic [TW-1:0] spin_timer;
  logic [TW-1:0] toner_timer [4];
  logic [15:0]   scan_timer [4];
  logic [TW-1:0] win_timer;
  logic [15:0]   beat_count;
  logic          win_active;
  logic [3:0]    streak [4];
  logic [TW-1:0] ctr_timer [2];
  logic [TW-1:0] seq_timer;
  logic [TW-1:0] proc_timer;
  logic [1:0]    boot_count;
  logic          ap_valid;
  logic          ap_write;
  logic [11:0]   ap_addr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge history
  always_ff @(posedge clk) begin
    meta <= pins;
    s    <= meta;
    prev <= s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive motors
  always_ff @(posedge clk) begin
    if (reset) begin
      mstate <= DFS_M_IDLE;
      mtimer <= '0;
    end else begin
      unique case (mstate)
        DFS_M_IDLE: begin
          mtimer <= '0;
          if (s.main_on_cmd) begin
            mstate <= DFS_M_RUNUP;
          end
        end
        DFS_M_RUNUP: begin
          mtimer <= mtimer + 1'b1;
          if (!s.main_on_cmd) begin
            mstate <= DFS_M_STOP;
            mtimer <= '0;
          end else if (mtimer >= RUNUP_L - 1'b1) begin
            mstate <= DFS_M_RUN;
          end
        end
        DFS_M_RUN: begin
          mtimer <= '0;
          if (!s.main_on_cmd) begin
            mstate <= DFS_M_STOP;
          end
        end
        DFS_M_STOP: begin
          mtimer <= mtimer + 1'b1;
          if (s.main_on_cmd) begin
            mstate <= DFS_M_RUNUP;
            mtimer <= '0;
          end else if (mtimer >= STOP_L - 1'b1) begin
            mstate <= DFS_M_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Polygon spin-up, power-on setting check
  always_ff @(posedge clk) begin
    if (reset) begin
      spin_timer <= '0;
      boot_count <= '0;
    end else begin
      if (spin_timer < SPINUP_L) begin
        spin_timer <= spin_timer + 1'b1;
      end
      if (boot_count != 2'h3) begin
        boot_count <= boot_count + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per colour timers
  for (genvar c = 0; c < 4; c++) begin : g_colour
    always_ff @(posedge clk) begin
      if (reset || !s.toner_motor_on[c] || !s.toner_low[c]) begin
        toner_timer[c] <= '0;
      end else if (toner_timer[c] < TONER_L) begin
        toner_timer[c] <= toner_timer[c] + 1'b1;
      end
    end
    always_ff @(posedge clk) begin
      if (reset || !s.laser_on[c] || (s.scan_sync[c] && !prev.scan_sync[c])) begin
        scan_timer[c] <= '0;
      end else if (scan_timer[c] != 16'hFFFF) begin
        scan_timer[c] <= scan_timer[c] + 1'b1;
      end
    end
    always_ff @(posedge clk) begin
      if (reset) begin
        streak[c] <= '0;
      end else if (s.pattern_done && !prev.pattern_done && s.pattern_colour == 2'(c)) begin
        if ({1'b0, s.vsp_mv} > {1'b0, s.vtc_mv} + 14'(`DFS_PAT_MARGIN_MV)) begin
          if (streak[c] != 4'(`DFS_PAT_STREAK)) begin
            streak[c] <= streak[c] + 1'b1;
          end
        end else begin
          streak[c] <= '0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line sync rate window
  always_ff @(posedge clk) begin
    if (reset || win_timer >= WINDOW_L - 1'b1) begin
      win_timer  <= '0;
      beat_count <= '0;
      win_active <= 1'b1;
    end else begin
      win_timer <= win_timer + 1'b1;
      if (!(|s.laser_on)) begin
        win_active <= 1'b0;
      end
      if (s.line_beam && !prev.line_beam && beat_count != 16'hFFFF) begin
        beat_count <= beat_count + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Copy counters and heartbeats
  for (genvar k = 0; k < 2; k++) begin : g_counter
    always_ff @(posedge clk) begin
      if (reset || (s.counter_want[k] == s.counter_line[k])) begin
        ctr_timer[k] <= '0;
      end else if (ctr_timer[k] < GRACE_L) begin
        ctr_timer[k] <= ctr_timer[k] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset || (s.seq_beat && !prev.seq_beat)) begin
      seq_timer <= '0;
    end else if (seq_timer <= SEQ_L) begin
      seq_timer <= seq_timer + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || (s.proc_beat && !prev.proc_beat)) begin
      proc_timer <= '0;
    end else if (proc_timer <= PROC_L) begin
      proc_timer <= proc_timer + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault conditions
  always_comb begin
    raise = '0;
    raise[`DFS_F_MAIN_SPEED] = (mstate == DFS_M_RUNUP && mtimer >= RUNUP_L - 1'b1 && !s.at_speed[0])
                             || (mstate == DFS_M_RUN && !s.at_speed[0]);
    raise[`DFS_F_DRUM_SPEED] = (mstate == DFS_M_RUNUP && mtimer >= RUNUP_L - 1'b1 && !s.at_speed[1])
                             || (mstate == DFS_M_RUN && !s.at_speed[1]);
    raise[`DFS_F_BELT_SPEED] = (mstate == DFS_M_RUNUP && mtimer >= RUNUP_L - 1'b1 && !s.at_speed[2])
                             || (mstate == DFS_M_RUN && !s.at_speed[2]);
    raise[`DFS_F_MAIN_STOP]  = mstate == DFS_M_STOP && mtimer >= STOP_L - 1'b1 && s.main_turning;
    raise[`DFS_F_DRUM_STOP]  = mstate == DFS_M_STOP && mtimer >= STOP_L - 1'b1 && s.belt_turning;
    raise[`DFS_F_BELT_STOP]  = mstate == DFS_M_STOP && mtimer >= STOP_L - 1'b1 && s.belt_turning;
    raise[`DFS_F_MIRROR]     = spin_timer >= SPINUP_L && !s.mirror_at_speed;
    for (int c = 0; c < 4; c++) begin
      raise[`DFS_F_TONER + c]     = toner_timer[c] >= TONER_L;
      raise[`DFS_F_SCAN_SYNC + c] = scan_timer[c] > sync_limit;
      raise[`DFS_F_LASER + c]     = s.laser_over[c];
      raise[`DFS_F_CHARGE + c]    = s.charge_check && !prev.charge_check && !s.charge_ok[c];
      raise[`DFS_F_LEAK + c]      = s.leak[c];
      raise[`DFS_F_DENSITY + c]   = s.density_done && !prev.density_done && s.density_colour == 2'(c)
                                  && (s.density_volts < 9'(`DFS_DENS_MIN_V)
                                  || s.density_volts > 9'(`DFS_DENS_MAX_V));
      raise[`DFS_F_PATTERN + c]   = streak[c] == 4'(`DFS_PAT_STREAK);
    end
    for (int b = 0; b < 12; b++) begin
      raise[`DFS_F_BIAS + b] = s.bias_check && !prev.bias_check && s.bias_on[b] && !s.bias_ok[b];
    end
    raise[`DFS_F_LINE_SYNC] = win_timer >= WINDOW_L - 1'b1 && win_active
                            && (|s.laser_on) && beat_count < LINE_L;
    for (int k = 0; k < 2; k++) begin
      raise[`DFS_F_COUNTER + k] = ctr_timer[k] >= GRACE_L;
    end
    for (int l = 0; l < 5; l++) begin
      raise[`DFS_F_LINK + l] = s.link_lost[l];
    end
    raise[`DFS_F_SEQ_BEAT]  = seq_timer > SEQ_L;
    raise[`DFS_F_PROC_BEAT] = proc_timer > PROC_L;
    raise[`DFS_F_SETTING]   = boot_count == 2'h2
                            && (s.fuse_setting < FUSE_MIN || s.fuse_setting > FUSE_MAX);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky faults and priority report
  always_ff @(posedge clk) begin
    if (reset) begin
      faults <= '0;
    end else begin
      faults <= faults | raise;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fault_active <= 1'b0;
      fault_code   <= '0;
    end else begin
      fault_active <= |faults;
      fault_code   <= '0;
      for (int i = `DFS_NUM_FAULTS - 1; i >= 0; i--) begin
        if (faults[i]) begin
          fault_code <= 6'(i);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk) begin
    if (reset) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= '0;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_limit <= `DFS_SYNC_LIMIT_RST;
    end else if (ap_valid && ap_write && ap_addr == `DFS_REG_SYNC_LIMIT) begin
      sync_limit <= hwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata <= '0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr)
        `DFS_REG_FAULT_LO:   hrdata <= faults[31:0];
        `DFS_REG_FAULT_HI:   hrdata <= faults[63:32];
        `DFS_REG_CODE:       hrdata <= {16'h0000, 8'(fault_active), 2'b00, fault_code};
        `DFS_REG_SYNC_LIMIT: hrdata <= {16'h0000, sync_limit};
        default:             hrdata <= '0;
      endcase
    end
  end

endmodule : dfs_supervisor

// [tb/dfs_checker.sv]
// Assertion checker for the drive and imaging fault supervisor.
// Bound to dfs_supervisor; sees only its ports, one clock domain.
`timescale 1ns/10ps
module dfs_checker
  import dfs_pkg::*;
#(
  parameter longint unsigned RUNUP_CYC = 20,
  parameter longint unsigned STOP_CYC  = 40,
  parameter longint unsigned SEQ_CYC   = 30,
  parameter longint unsigned PROC_CYC  = 60,
  parameter logic [7:0]      FUSE_MIN  = 8'h50,
  parameter logic [7:0]      FUSE_MAX  = 8'hD0
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire dfs_pins_s  pins,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       fault_active,
  input wire logic [5:0] fault_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////
  // Gap counters
  logic [31:0] seq_gap;
  logic [31:0] proc_gap;
  logic [31:0] run_gap;
  logic [31:0] stop_gap;
  always_ff @(posedge clk) seq_gap <= (reset || $rose(pins.seq_beat)) ? 32'h0 : seq_gap + 32'h1;
  always_ff @(posedge clk) proc_gap <= (reset || $rose(pins.proc_beat)) ? 32'h0 : proc_gap + 32'h1;
  always_ff @(posedge clk) run_gap <= (pins.main_on_cmd && !pins.at_speed[0]) ? run_gap + 32'h1 : 32'h0;
  always_ff @(posedge clk) stop_gap <= (!pins.main_on_cmd && pins.main_turning) ? stop_gap + 32'h1 : 32'h0;
  ////////////////////////////////////////////////////////////////////////
  sequence s_over_seen;
    (|pins.laser_over) ##1 (|pins.laser_over);
  endsequence
  sequence s_bad_setting;
    $fell(reset) ##0 (pins.fuse_setting < FUSE_MIN || pins.fuse_setting > FUSE_MAX);
  endsequence
  a_leak_raise: assert property ((|pins.leak) |-> ##[0:8] fault_active)
    else $error("leak seen without fault");
  a_laser_raise: assert property (s_over_seen |-> ##[0:8] fault_active)
    else $error("laser overcurrent without fault");
  a_seq_beat: assert property (seq_gap > SEQ_CYC + 8 |-> fault_active)
    else $error("missing sequence beat not flagged");
  a_proc_beat: assert property (proc_gap > PROC_CYC + 8 |-> fault_active)
    else $error("missing process beat not flagged");
  a_runup_late: assert property (run_gap > RUNUP_CYC + 8 |-> fault_active)
    else $error("slow run-up not flagged");
  a_stop_late: assert property (stop_gap > STOP_CYC + 8 |-> fault_active)
    else $error("late stop not flagged");
  a_setting_range: assert property (s_bad_setting |-> ##[1:8] fault_active)
    else $error("bad stored setting not flagged");
  a_fault_sticky: assert property (fault_active |=> fault_active)
    else $error("fault dropped before reset");
  a_code_order: assert property (fault_active && $past(fault_active) |-> fault_code <= $past(fault_code))
    else $error("reported code rose");
  a_clean_start: assert property ($fell(reset) |-> !fault_active [*2])
    else $error("fault shown straight after reset");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
endmodule : dfs_checker

// [tb/dfs_partner.sv]
// Far side model: motor drivers, polygon driver, beam detector, peer boards.
// Shares the supervisor clock; knobs come from the bench.
`timescale 1ns/10ps
module dfs_partner (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       main_on,
  input  wire logic       seq_en,
  input  wire logic       proc_en,
  input  wire logic       mirror_ok,
  input  wire logic       beam_en,
  input  wire logic       sync_en,
  input  wire logic [7:0] spin_dly,
  input  wire logic [7:0] stop_main,
  input  wire logic [7:0] stop_belt,
  output logic      [2:0] at_speed,
  output logic            main_turning,
  output logic            belt_turning,
  output logic            mirror_at_speed,
  output logic            seq_beat,
  output logic            proc_beat,
  output logic            line_beam,
  output logic      [3:0] scan_sync
);
  logic [15:0] tick;
  logic [7:0]  since;
  logic        last_on;
  always_ff @(posedge clk) tick <= reset ? 16'h0 : tick + 16'h1;
  ////////////////////////////////////////////////////////////////////////
  // Cycles since the main command last changed
  always_ff @(posedge clk) begin
    last_on <= main_on;
    since   <= reset ? 8'hFF : (main_on != last_on) ? 8'h00 : (since == 8'hFF) ? since : since + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    at_speed        <= {3{main_on && last_on && since >= spin_dly}};
    main_turning    <= main_on || last_on || since < stop_main;
    belt_turning    <= main_on || last_on || since < stop_belt;
    mirror_at_speed <= mirror_ok && tick >= 16'h0032;
    seq_beat        <= seq_en && tick[3];
    proc_beat       <= proc_en && tick[4];
    line_beam       <= beam_en && tick[2];
    scan_sync       <= {4{sync_en && tick[2]}};
  end
endmodule : dfs_partner

// [tb/dfs_supervisor_tb.sv]
// Self-checking bench for the fault supervisor, random colour and index.
// Assumes shortened timing parameters and the partner model.
`timescale 1ns/10ps
`include "dfs_defines.svh"
module dfs_supervisor_tb
  import dfs_pkg::*;
;
  localparam longint unsigned RUNUP = 20, STOP = 40, SPIN = 200, TONER = 100;
  localparam longint unsigned SEQ = 30, PROC = 60, WIN = 200, GRACE = 10;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  dfs_pins_s   pins_tb, pins;
  logic        hsel, hwrite, hreadyout, hresp, fault_active;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic [5:0]  fault_code;
  logic        seq_en, proc_en, mirror_ok, beam_en, sync_en;
  logic [7:0]  spin_dly, stop_main, stop_belt;
  logic [2:0]  p_speed;
  logic        p_main, p_belt, p_mirror, p_seq, p_proc, p_beam;
  logic [3:0]  p_sync, strb;
  int          error_cnt = 0, n_compared = 0, cycles = 0;
  always #50 clk = ~clk;
  always_comb begin
    pins = pins_tb;
    pins.at_speed = p_speed;
    pins.main_turning = p_main;
    pins.belt_turning = p_belt;
    pins.mirror_at_speed = p_mirror;
    pins.seq_beat = p_seq;
    pins.proc_beat = p_proc;
    pins.line_beam = p_beam;
    pins.scan_sync = p_sync;
    {pins.bias_check, pins.charge_check, pins.density_done, pins.pattern_done} = strb;
  end
  dfs_supervisor #(.RUNUP_CYC(RUNUP), .STOP_CYC(STOP), .SPINUP_CYC(SPIN), .TONER_CYC(TONER), .SEQ_CYC(SEQ),
    .PROC_CYC(PROC), .WINDOW_CYC(WIN), .GRACE_CYC(GRACE), .LINE_MIN(3)) i_dfs_supervisor (
    .clk(clk), .reset(reset), .pins(pins), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .fault_active(fault_active), .fault_code(fault_code));
  dfs_partner i_dfs_partner (.clk(clk), .reset(reset), .main_on(pins_tb.main_on_cmd), .seq_en(seq_en),
    .proc_en(proc_en), .mirror_ok(mirror_ok), .beam_en(beam_en), .sync_en(sync_en), .spin_dly(spin_dly),
    .stop_main(stop_main), .stop_belt(stop_belt), .at_speed(p_speed), .main_turning(p_main),
    .belt_turning(p_belt), .mirror_at_speed(p_mirror), .seq_beat(p_seq), .proc_beat(p_proc),
    .line_beam(p_beam), .scan_sync(p_sync));
  ////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask : chk
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task rd_faults(output logic [63:0] f);
    logic [31:0] lo, hi;
    xfer(1'b0, `DFS_REG_FAULT_LO, 32'h0, lo);
    xfer(1'b0, `DFS_REG_FAULT_HI, 32'h0, hi);
    f = {hi, lo};
  endtask : rd_faults
  task strobe(input logic [3:0] m);
    repeat (3) @(posedge clk);
    strb <= m;
    repeat (3) @(posedge clk);
    strb <= 4'h0;
  endtask : strobe
  function logic [5:0] lowest(input logic [63:0] f);
    lowest = 6'h0;
    for (int i = 63; i >= 0; i--)
      if (f[i]) lowest = 6'(i);
  endfunction : lowest
  function logic [63:0] exp_mask(input int k, input int c, input int b);
    case (k)
      0: exp_mask = 64'h1 << (`DFS_F_LEAK + c);
      1: exp_mask = 64'h1 << (`DFS_F_LASER + c);
      2: exp_mask = 64'h1 << (`DFS_F_LINK + b % 5);
      3: exp_mask = 64'h1 << (`DFS_F_COUNTER + b % 2);
      4: exp_mask = 64'h1 << `DFS_F_SEQ_BEAT;
      5: exp_mask = 64'h1 << `DFS_F_PROC_BEAT;
      6: exp_mask = 64'h1 << `DFS_F_SETTING;
      7: exp_mask = 64'h1 << `DFS_F_MIRROR;
      8: exp_mask = 64'h15;
      9: exp_mask = 64'h1 << `DFS_F_MAIN_STOP;
      10: exp_mask = 64'h28;
      11: exp_mask = 64'h1 << (`DFS_F_TONER + c);
      12: exp_mask = (64'h1 << (`DFS_F_LEAK + c)) | (64'h1 << (`DFS_F_LASER + c));
      13: exp_mask = 64'h1 << (`DFS_F_PATTERN + c);
      14: exp_mask = 64'h1 << (`DFS_F_DENSITY + c);
      15: exp_mask = 64'h1 << (`DFS_F_BIAS + b);
      16: exp_mask = 64'h1 << (`DFS_F_CHARGE + c);
      17: exp_mask = 64'h1 << `DFS_F_LINE_SYNC;
      default: exp_mask = 64'h1 << (`DFS_F_SCAN_SYNC + c);
    endcase
  endfunction : exp_mask
  ////////////////////////////////////////////////////////////////////////
  task run_case(input int k);
    dfs_pins_s   d;
    logic [63:0] e, f;
    logic [31:0] r;
    int          c, b;
    c = $urandom % 4;
    b = $urandom % 12;
    d = '0;
    d.charge_ok = 4'hF;
    d.bias_ok = 12'hFFF;
    d.fuse_setting = (k != 6) ? `DFS_FUSE_MAX : b[0] ? `DFS_FUSE_MAX + 8'h01 : `DFS_FUSE_MIN - 8'h01;
    pins_tb <= d;
    seq_en <= (k != 4);
    proc_en <= (k != 5);
    mirror_ok <= (k != 7);
    beam_en <= (k != 17);
    sync_en <= (k != 18);
    spin_dly <= (k == 8) ? 8'h1E : 8'h05;
    stop_main <= (k == 9) ? 8'h50 : 8'h05;
    stop_belt <= (k == 10) ? 8'h50 : 8'h05;
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    if (k == 0) begin
      xfer(1'b1, `DFS_REG_FAULT_LO, 32'hFFFFFFFF, r);
      xfer(1'b0, `DFS_REG_FAULT_LO, 32'h0, r);
      chk(r, 32'h0);
      xfer(1'b0, `DFS_REG_SYNC_LIMIT, 32'h0, r);
      chk(r, 32'(`DFS_SYNC_LIMIT_RST));
      xfer(1'b0, 12'h010, 32'h0, r);
      chk(r, 32'h0);
    end
    case (k)
      0: d.leak[c] = 1'b1;
      1: d.laser_over[c] = 1'b1;
      2: d.link_lost[b % 5] = 1'b1;
      3: {d.counter_want[b % 2], d.counter_line[b % 2]} = b[2] ? 2'b10 : 2'b01;
      8, 9, 10: d.main_on_cmd = 1'b1;
      11: {d.toner_motor_on[c], d.toner_low[c]} = 2'b11;
      12: {d.leak[c], d.laser_over[c]} = 2'b11;
      13: {d.pattern_colour, d.vtc_mv} = {2'(c), 13'(b * 300)};
      14: {d.density_colour, d.density_volts} = {2'(c), b[0] ? 9'h15D : 9'h1C3};
      15: {d.bias_on, d.bias_ok} = {12'hFFF, ~(12'h001 << b)};
      16: d.charge_ok[c] = 1'b0;
      17, 18: d.laser_on[c] = 1'b1;
      default: d.main_on_cmd = 1'b0;
    endcase
    pins_tb <= d;
    if (k == 18) begin
      xfer(1'b1, `DFS_REG_SYNC_LIMIT, 32'h28, r);
      xfer(1'b0, `DFS_REG_SYNC_LIMIT, 32'h0, r);
      chk(r, 32'h28);
    end
    if (k == 9 || k == 10) begin
      repeat (40) @(posedge clk);
      d.main_on_cmd = 1'b0;
      pins_tb <= d;
    end
    if (k >= 14 && k <= 16) strobe((k == 14) ? 4'h2 : (k == 15) ? 4'h8 : 4'h4);
    if (k == 13) begin
      @(posedge clk);
      for (int i = 0; i < 30; i++) begin
        d.vsp_mv = d.vtc_mv + ((i == 14) ? 13'h3E8 : 13'h3E9);
        pins_tb <= d;
        if (i == 29) begin
          repeat (8) @(posedge clk);
          rd_faults(f);
          chk(f, 64'h0);
        end
        strobe(4'h1);
      end
    end
    repeat (500) @(posedge clk);
    e = exp_mask(k, c, b);
    rd_faults(f);
    chk(f, e);
    xfer(1'b0, `DFS_REG_CODE, 32'h0, r);
    chk(r, {23'h0, |e, 2'b00, lowest(e)});
    chk({fault_active, fault_code}, {|e, lowest(e)});
  endtask : run_case
  ////////////////////////////////////////////////////////////////////////
  initial begin
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 12'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    strb = 4'h0;
    pins_tb = '0;
    void'($urandom(32'hD9C9));
    for (int p = 0; p < 2; p++)
      for (int k = 0; k < 19; k++)
        run_case(k);
    report_and_stop();
  end
endmodule : dfs_supervisor_tb

bind dfs_supervisor dfs_checker #(.RUNUP_CYC(RUNUP_CYC), .STOP_CYC(STOP_CYC), .SEQ_CYC(SEQ_CYC),
  .PROC_CYC(PROC_CYC), .FUSE_MIN(FUSE_MIN), .FUSE_MAX(FUSE_MAX)) i_dfs_checker (.clk(clk), .reset(reset),
  .pins(pins), .hreadyout(hreadyout), .hresp(hresp), .fault_active(fault_active), .fault_code(fault_code));
